// [common/run_control_pkg.sv]
// Purpose: Shared constants and types for the processor run-control block.
// Assumes: One controller clock at 250 MHz; the phase clock arrives as a pin.
// Notes: The reset values below describe the idle, released processor.
package run_control_pkg;

  // Reset value of the micro-go flip-flop: processor clock not permitted.
  localparam logic MICRO_GO_RST = 1'b0;
  // Reset value of the takeover interrupt request, active low: released.
  localparam logic TAKEOVER_IRQ_N_RST = 1'b1;
  // Number of stages in each pin synchroniser.
  localparam int SYNC_STAGES = 2;

  // Clock source selection for the controller timing chain.
  typedef enum logic [0:0] {
    CLK_SRC_INTERNAL = 1'b0,
    CLK_SRC_PHASE = 1'b1
  } clk_src_t;

endpackage

// [common/run_event_if.sv]
// Purpose: Carries qualified run events from the decode stage to the core.
// Assumes: Both ends sit on core_clk_i.
// Notes: Decoded members are registered levels that last as long as their qualified inputs hold; req_ctrl, release_ctrl and micro_mode are tied low.
`timescale 1ns/1ps
`default_nettype none
interface run_event_if;
  logic go_term;
  logic stop_term;
  logic req_ctrl;
  logic release_ctrl;
  logic micro_bp;
  logic macro_bp;
  logic macro_step;
  logic micro_mode;

  modport src (
    output go_term,
    output stop_term,
    output req_ctrl,
    output release_ctrl,
    output micro_bp,
    output macro_bp,
    output macro_step,
    output micro_mode
  );
  modport dst (
    input go_term,
    input stop_term,
    input req_ctrl,
    input release_ctrl,
    input micro_bp,
    input macro_bp,
    input macro_step,
    input micro_mode
  );
endinterface
`default_nettype wire

// [logic/run_event_decode.sv]
// Purpose: Synchronises pin inputs and forms the go and stop terms.
// Assumes: Command, step and breakpoint inputs are outside the clock domain.
// Notes: Terms are registered, so each reaches the core one cycle late.
`timescale 1ns/1ps
`default_nettype none
module run_event_decode (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Raw inputs.
  input wire logic [10:0] raw_i,
  // Events toward the core.
  run_event_if.src ev
);
  import run_control_pkg::*;

  typedef struct packed {
    logic [10:0] meta;
    logic [10:0] sync;
    logic go_term;
    logic stop_term;
    logic req_ctrl;
    logic release_ctrl;
    logic micro_bp;
    logic macro_bp;
    logic macro_step;
  } dec_state_t;

  dec_state_t state_reg;
  dec_state_t state_next;
  logic go_cmd, stop_cmd, auto_disp, cnt_zero, term, dr_clr;
  logic step_en, eds, fetch_ref, bp_match, owns;

  // Synchronised bit order follows raw_i.
  assign {owns, bp_match, fetch_ref, eds, step_en, dr_clr, term, cnt_zero,
          auto_disp, stop_cmd, go_cmd} = state_reg.sync;

  // Terms come only from the second synchroniser stage.
  always_comb begin
    state_next = state_reg;
    state_next.meta = raw_i;
    state_next.sync = state_reg.meta;
    // Go: command entered, or auto-display on a bare terminator.
    state_next.go_term = (go_cmd | auto_disp) & cnt_zero & term &
                         dr_clr;
    // Stop command counts only outside auto-display.
    state_next.stop_term = stop_cmd & ~auto_disp & cnt_zero & term &
                           dr_clr;
    // Breakpoints compare only while the processor runs on its own.
    state_next.micro_bp = bp_match & ~owns;
    state_next.macro_bp = bp_match & ~owns;
    state_next.macro_step = step_en & eds & fetch_ref;
    if (!rst_n_i) begin
      state_next = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    state_reg <= state_next;
  end

  assign ev.go_term = state_reg.go_term;
  assign ev.stop_term = state_reg.stop_term;
  assign ev.micro_bp = state_reg.micro_bp;
  assign ev.macro_bp = state_reg.macro_bp;
  assign ev.macro_step = state_reg.macro_step;
  // The request and release pulses come from same-domain controlware.
  assign ev.req_ctrl = 1'b0;
  assign ev.release_ctrl = 1'b0;
  assign ev.micro_mode = 1'b0;
endmodule
`default_nettype wire

// [logic/processor_run_control.sv]
// Purpose: Takeover, release, go and stop control of the host processor.
// Assumes: Controlware pulses and mode bits are on core_clk_i.
// Notes: Processor pins pass three flip-flops in the decode stage.
`timescale 1ns/1ps
`default_nettype none
module processor_run_control (
  // Clock and master clear.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Controlware and function control word bits.
  input wire logic request_processor_control_i,
  input wire logic release_processor_i,
  input wire logic micro_mode_select_i,
  input wire logic auto_display_enable_i,
  input wire logic single_step_enable_i,
  // Command decode, asynchronous to this clock.
  input wire logic go_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic char_count_zero_i,
  input wire logic terminator_received_i,
  input wire logic data_ready_cleared_i,
  // Processor status pins.
  input wire logic cpu_end_cycle_strobe_i,
  input wire logic instruction_fetch_reference_i,
  input wire logic breakpoint_match_i,
  // Toward processor clock control and emulator.
  output logic takeover_prep_request_n_o,
  output logic takeover_interrupt_request_n_o,
  output logic controller_owns_processor_o,
  output logic micro_run_go_o,
  output logic micro_run_halt_o,
  output logic macro_run_go_o,
  output logic macro_run_halt_o,
  output run_control_pkg::clk_src_t clk_source_o
);
  import run_control_pkg::*;

  typedef struct packed {
    logic micro_go;
    logic irq_n;
    logic macro_go;
    logic macro_halt;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;
  logic micro_step;
  logic micro_stop_ev;
  logic macro_stop_ev;
  logic owns;

  run_event_if ev ();

  // Processor-side inputs are synchronised and qualified here.
  run_event_decode u_decode (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .raw_i({controller_owns_processor_o, breakpoint_match_i,
            instruction_fetch_reference_i, cpu_end_cycle_strobe_i,
            single_step_enable_i, data_ready_cleared_i,
            terminator_received_i, char_count_zero_i,
            auto_display_enable_i, stop_cmd_i, go_cmd_i}),
    .ev(ev)
  );

  // Owning is read straight from the interrupt flip-flop.
  assign owns = ~state_reg.irq_n;
  assign micro_step = single_step_enable_i & owns;
  // Four micro stop sources, all gated by micro mode.
  assign micro_stop_ev = micro_mode_select_i & (ev.stop_term |
                         release_processor_i | micro_step |
                         ev.micro_bp);
  // Three macro stop sources, gated by macro mode.
  assign macro_stop_ev = ~micro_mode_select_i & (ev.stop_term |
                         ev.macro_step | ev.macro_bp);

  // Next-state logic; in micro mode a go and a stop together let the stop win at micro_go,
  // while in macro mode macro_go and macro_halt both pulse; halting is the safe outcome.
  always_comb begin
    state_next = state_reg;
    // Request takes over the processor; release hands it back.
    if (request_processor_control_i) begin
      state_next.irq_n = 1'b0;
    end else if (release_processor_i) begin
      state_next.irq_n = 1'b1;
    end
    if (ev.go_term | request_processor_control_i) begin
      state_next.micro_go = 1'b1;
    end
    if (micro_stop_ev) begin
      state_next.micro_go = 1'b0;
    end
    state_next.macro_go = ev.go_term & ~micro_mode_select_i;
    state_next.macro_halt = macro_stop_ev;
    if (!rst_n_i) begin
      state_next.micro_go = MICRO_GO_RST;
      state_next.irq_n = TAKEOVER_IRQ_N_RST;
      state_next.macro_go = 1'b0;
      state_next.macro_halt = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    state_reg <= state_next;
  end

  // Prep request is combinational so the processor sees it on the pulse.
  assign takeover_prep_request_n_o =
    ~(micro_mode_select_i & request_processor_control_i);
  assign takeover_interrupt_request_n_o = state_reg.irq_n;
  assign controller_owns_processor_o = ~state_reg.irq_n;
  assign micro_run_go_o = state_reg.micro_go;
  assign micro_run_halt_o = ~state_reg.micro_go;
  assign macro_run_go_o = state_reg.macro_go;
  assign macro_run_halt_o = state_reg.macro_halt;
  // The emulator tracks its run status bit from these pulses.
  // Timing chain source follows ownership.
  assign clk_source_o = owns ? CLK_SRC_PHASE : CLK_SRC_INTERNAL;

  chk_takeover_on_request: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    request_processor_control_i |=> !takeover_interrupt_request_n_o)
    else $error("Takeover request not taken.");
  chk_release_clears: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    release_processor_i && !request_processor_control_i
    |=> takeover_interrupt_request_n_o)
    else $error("Release did not clear takeover.");
  chk_owns_complement: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    controller_owns_processor_o != takeover_interrupt_request_n_o)
    else $error("Ownership not complement of request.");
  chk_prep_micro_only: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !takeover_prep_request_n_o |-> micro_mode_select_i)
    else $error("Prep request outside micro mode.");
  chk_micro_go_request: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    request_processor_control_i && !micro_stop_ev |=> micro_run_go_o)
    else $error("Micro go missed request.");
  chk_micro_stop_halts: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    micro_stop_ev |=> micro_run_halt_o && !micro_run_go_o)
    else $error("Micro stop did not halt.");
  chk_macro_go_mode: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    macro_run_go_o |-> $past(!micro_mode_select_i))
    else $error("Macro go in micro mode.");
  chk_macro_halt_mode: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    macro_run_halt_o |-> $past(!micro_mode_select_i))
    else $error("Macro halt in micro mode.");
  chk_clock_source: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (clk_source_o == CLK_SRC_PHASE) == controller_owns_processor_o)
    else $error("Clock source disagrees with ownership.");

  // The properties below sample on the controller clock and stay quiet
  // during master clear; only the two clear checks watch the clear.

  // Master clear leaves the processor released and its clock held.
  chk_clear_idles: assert property (
    @(posedge core_clk_i)
    !rst_n_i |=> takeover_interrupt_request_n_o && !micro_run_go_o)
    else $error("Master clear did not idle the run control.");

  // No run pulse may leak out straight after a master clear.
  chk_clear_pulses: assert property (
    @(posedge core_clk_i)
    !rst_n_i |=> !macro_run_go_o && !macro_run_halt_o)
    else $error("Run pulse active after master clear.");

  // The prep request follows the request pulse in micro mode.
  chk_prep_on_request: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    micro_mode_select_i && request_processor_control_i
    |-> !takeover_prep_request_n_o)
    else $error("Prep request missing in micro mode.");

  // A request always ends with the controller owning the processor.
  chk_request_owns: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    request_processor_control_i |=> controller_owns_processor_o)
    else $error("Request did not take over the processor.");

  // The takeover interrupt only falls after a request pulse.
  chk_irq_fall_cause: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(takeover_interrupt_request_n_o)
    |-> $past(request_processor_control_i))
    else $error("Takeover interrupt fell without a request.");

  // The takeover interrupt only rises after a release with no request.
  chk_irq_rise_cause: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(takeover_interrupt_request_n_o)
    |-> $past(release_processor_i) && !$past(request_processor_control_i))
    else $error("Takeover interrupt rose without a release.");

  // Leaving the processor stops the micro clock in micro mode.
  chk_release_stops_micro: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    micro_mode_select_i && release_processor_i |=> !micro_run_go_o)
    else $error("Release did not stop the micro clock.");

  // A single step while owning stops the micro clock in micro mode.
  chk_micro_step_stops: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    micro_mode_select_i && single_step_enable_i &&
    controller_owns_processor_o |=> !micro_run_go_o)
    else $error("Micro step did not stop the micro clock.");

  // A stop command stops the micro clock in micro mode.
  chk_stop_term_micro: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    micro_mode_select_i && ev.stop_term |=> !micro_run_go_o)
    else $error("Stop command did not stop the micro clock.");

  // A micro breakpoint match stops the micro clock in micro mode.
  chk_micro_bp_stops: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    micro_mode_select_i && ev.micro_bp |=> !micro_run_go_o)
    else $error("Micro breakpoint did not stop the micro clock.");

  // A go term starts the micro clock in either mode unless a stop wins.
  chk_go_starts_micro: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    ev.go_term && !micro_stop_ev |=> micro_run_go_o)
    else $error("Go term did not start the micro clock.");

  // With no go, request or stop the micro clock permission holds.
  chk_micro_go_holds: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !ev.go_term && !request_processor_control_i && !micro_stop_ev
    |=> $stable(micro_run_go_o))
    else $error("Micro clock state changed with no cause.");

  // In macro mode nothing may stop the micro clock.
  chk_macro_keeps_micro: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !micro_mode_select_i && micro_run_go_o |=> micro_run_go_o)
    else $error("Micro clock stopped in macro mode.");

  // A go term in macro mode sends the macro go pulse.
  chk_macro_go_term: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !micro_mode_select_i && ev.go_term |=> macro_run_go_o)
    else $error("Macro go missing after go term.");

  // Every macro go pulse has a go term behind it.
  chk_macro_go_cause: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    macro_run_go_o |-> $past(ev.go_term))
    else $error("Macro go without a go term.");

  // A stop command in macro mode sends the macro stop pulse.
  chk_halt_on_stop: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !micro_mode_select_i && ev.stop_term |=> macro_run_halt_o)
    else $error("Macro stop missing after stop command.");

  // A macro single step sends the macro stop pulse.
  chk_halt_on_step: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !micro_mode_select_i && ev.macro_step |=> macro_run_halt_o)
    else $error("Macro stop missing after macro step.");

  // A macro breakpoint match sends the macro stop pulse.
  chk_halt_on_bp: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !micro_mode_select_i && ev.macro_bp |=> macro_run_halt_o)
    else $error("Macro stop missing after macro breakpoint.");

  // Every macro stop pulse has one of its three causes behind it.
  chk_macro_halt_cause: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    macro_run_halt_o |-> $past(ev.stop_term) || $past(ev.macro_step) ||
    $past(ev.macro_bp))
    else $error("Macro stop without a cause.");

  // Ownership reaches the compare through the synchroniser, so a match
  // is masked three edges after the controller took the processor.
  chk_bp_masked_owning: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(controller_owns_processor_o, 3)
    |-> !ev.micro_bp && !ev.macro_bp)
    else $error("Breakpoint seen while owning the processor.");

  // The internal clock drives the timing chain while released.
  chk_internal_when_free: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    takeover_interrupt_request_n_o |-> clk_source_o == CLK_SRC_INTERNAL)
    else $error("Phase clock selected while released.");
endmodule
`default_nettype wire

// [dv/emulator_model.sv]
// Purpose: Behavioural processor emulator for the bench, driven by the macro run pulses.
// Assumes: Pins change at the falling edge of core_clk_i.
// Notes: Ends a cycle every eighth clock while the macro run bit is set.
`timescale 1ns/1ps
`default_nettype none
module emulator_model (
  // Clock, reset and run pulses.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic macro_run_go_i,
  input wire logic macro_run_halt_i,
  // Processor status.
  output logic run_bit_o,
  output logic cpu_end_cycle_strobe_o,
  output logic instruction_fetch_reference_o
);
  logic [2:0] cnt_reg;
  // The fetch line toggles between strobes, so a stale level never
  // passes for a fetch at the end of a cycle.
  always @(negedge core_clk_i) begin
    if (!rst_n_i) begin
      run_bit_o <= 1'b0;
      cnt_reg <= 3'h0;
    end else begin
      if (macro_run_halt_i) run_bit_o <= 1'b0;
      else if (macro_run_go_i) run_bit_o <= 1'b1;
      cnt_reg <= cnt_reg + 3'h1;
    end
    cpu_end_cycle_strobe_o <= run_bit_o && cnt_reg == 3'h7;
    instruction_fetch_reference_o <= cnt_reg == 3'h7 || cnt_reg[0];
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench for the processor run control.
// Assumes: Stimulus changes at the falling edge.
// Notes: Outputs are compared on change, so latencies are not fixed here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import run_control_pkg::*;
  logic core_clk_i, rst_n_i, req, rel, mode, auto_en, step_en;
  logic go_c, stop_c, cz, term, drc, bp, strobe, fetch, run_bit;
  logic prep_n, irq_n, owns, ugo, uhalt, mgo, mhalt;
  clk_src_t src;
  logic [7:0] obs, prev;
  logic [15:0] q[$];
  logic [15:0] n;
  int num_errors, checked, seed;

  assign obs = {prep_n, irq_n, owns, ugo, uhalt, mgo, mhalt, logic'(src)};

  processor_run_control dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .request_processor_control_i(req), .release_processor_i(rel),
    .micro_mode_select_i(mode), .auto_display_enable_i(auto_en),
    .single_step_enable_i(step_en), .go_cmd_i(go_c), .stop_cmd_i(stop_c),
    .char_count_zero_i(cz), .terminator_received_i(term),
    .data_ready_cleared_i(drc), .cpu_end_cycle_strobe_i(strobe),
    .instruction_fetch_reference_i(fetch), .breakpoint_match_i(bp),
    .takeover_prep_request_n_o(prep_n),
    .takeover_interrupt_request_n_o(irq_n),
    .controller_owns_processor_o(owns), .micro_run_go_o(ugo),
    .micro_run_halt_o(uhalt), .macro_run_go_o(mgo),
    .macro_run_halt_o(mhalt), .clk_source_o(src));

  emulator_model partner (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .macro_run_go_i(mgo), .macro_run_halt_i(mhalt), .run_bit_o(run_bit),
    .cpu_end_cycle_strobe_o(strobe), .instruction_fetch_reference_o(fetch));

  // Free-running 250 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  task chk(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A note holds the mask of watched outputs above the expected value.
  task note(input logic [7:0] v, m);
    q.push_back({m, v});
  endtask

  // Bounded wait for the outstanding notes, then a few quiet cycles.
  task wait_q;
    for (int i = 0; i < 60 && q.size() != 0; i++) @(negedge core_clk_i);
    repeat (6) @(negedge core_clk_i);
  endtask

  // Presents a terminated command for a random number of cycles.
  task cmd(input logic g, s, a);
    {go_c, stop_c, auto_en, cz, term, drc} = {g, s, a, 3'h7};
    repeat (1 + $unsigned($random(seed)) % 4) @(negedge core_clk_i);
    {go_c, stop_c, auto_en, cz, term, drc} = 6'h00;
    wait_q;
  endtask

  task complete_run;
    if (q.size() != 0) num_errors++;
    $display("Checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Each change among the masked outputs consumes the oldest note.
  always @(posedge core_clk_i) begin
    if (rst_n_i && q.size() != 0 && ((obs ^ prev) & q[0][15:8]) != 8'h00) begin
      n = q.pop_front();
      chk("outputs", obs & n[15:8], n[7:0] & n[15:8]);
    end
    prev = obs;
  end

  // A hang counts as a mismatch.
  initial begin
    repeat (3000) @(posedge core_clk_i);
    num_errors++;
    complete_run;
  end

  // Takeover and release, micro go and stop, then macro go and stop.
  initial begin
    seed = 59650;
    {rst_n_i, req, rel, mode, auto_en, step_en} = 6'h00;
    {go_c, stop_c, cz, term, drc, bp} = 6'h00;
    num_errors = 0;
    checked = 0;
    repeat (5) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    chk("idle", obs, 8'hC8);
    for (int m = 1; m >= 0; m--) begin
      mode = m[0];
      if (m == 1) note(8'h48, 8'hFF);
      note(8'hB1, 8'hFF);
      req = 1'b1;
      @(negedge core_clk_i);
      req = 1'b0;
      wait_q;
      if (m == 1) begin
        note(8'hA9, 8'hFF);
        step_en = 1'b1;
        wait_q;
        step_en = 1'b0;
      end
      mode = 1'b1;
      note(8'hC8, 8'hFF);
      rel = 1'b1;
      @(negedge core_clk_i);
      rel = 1'b0;
      wait_q;
    end
    note(8'hD0, 8'hFF);
    cmd(1'b1, 1'b0, 1'b0);
    note(8'hC8, 8'hFF);
    bp = 1'b1;
    repeat (2) @(negedge core_clk_i);
    bp = 1'b0;
    wait_q;
    note(8'hD0, 8'hFF);
    cmd(1'b0, 1'b0, 1'b1);
    cmd(1'b0, 1'b1, 1'b1);
    note(8'hC8, 8'hFF);
    cmd(1'b0, 1'b1, 1'b0);
    mode = 1'b0;
    for (int k = 0; k < 3; k++) begin
      note(8'h04, 8'h04);
      note(8'h00, 8'h04);
      cmd(1'b1, 1'b0, 1'b0);
      chk("run bit", {7'h00, run_bit}, 8'h01);
      note(8'h02, 8'h02);
      note(8'h00, 8'h02);
      if (k == 0) begin
        step_en = 1'b1;
        wait_q;
        step_en = 1'b0;
      end else if (k == 1) begin
        cmd(1'b0, 1'b1, 1'b0);
      end else begin
        bp = 1'b1;
        repeat (2) @(negedge core_clk_i);
        bp = 1'b0;
        wait_q;
      end
      chk("run bit", {7'h00, run_bit}, 8'h00);
    end
    complete_run;
  end
endmodule
`default_nettype wire
